// ---- verilog/gps_framer_pkg.sv ----
/*
 * Shared constants and types for the GPS time packet framer: register
 * offsets, reset values, fixed header words, payload layout and timing.
 * Assumes a 20 MHz system clock and byte-wide NMEA and transmit streams.
 */
package gps_framer_pkg;
   // Register byte offsets on the plain register port.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SRC_IP = 8'h04;
   localparam logic [7:0] OFS_MAC_LO = 8'h08;
   localparam logic [7:0] OFS_MAC_HI = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_US     = 8'h14;
   localparam logic [7:0] OFS_PKTS   = 8'h18;
   // Control and status bit positions.
   localparam int CTRL_PTP_BIT  = 0;
   localparam int CTRL_GGA_BIT  = 1;
   localparam int STAT_NMEA_BIT = 0;
   localparam int STAT_PPS_BIT  = 1;
   localparam int STAT_BUSY_BIT = 2;
   // Reset values; the hardware address default is arbitrary.
   localparam logic [31:0] SRC_IP_RST = 32'hC0A801C9;
   localparam logic [47:0] MAC_RST    = 48'h020000000001;
   // Fixed header words.
   localparam logic [47:0] MAC_BCAST  = 48'hFFFFFFFFFFFF;
   localparam logic [15:0] ETH_TYPE   = 16'h0800;
   localparam logic [15:0] IP_VER_TOS = 16'h4500;
   localparam logic [15:0] IP_TOTLEN  = 16'h021C;
   localparam logic [15:0] IP_ID      = 16'h0000;
   localparam logic [15:0] IP_FRAG    = 16'h4000;
   localparam logic [15:0] IP_TTL_PRO = 16'h4011;
   localparam logic [31:0] IP_BCAST   = 32'hFFFFFFFF;
   localparam logic [15:0] UDP_SPORT  = 16'h2710;
   localparam logic [15:0] UDP_DPORT  = 16'h277E;
   localparam logic [15:0] UDP_LEN    = 16'h0208;
   localparam logic [15:0] UDP_CSUM   = 16'h0000;
   // Packet layout in bytes; payload offsets count from payload start.
   localparam logic [9:0] HDR_LEN   = 10'h02A;
   localparam logic [9:0] PKT_LAST  = 10'h229;
   localparam logic [9:0] P_DATE    = 10'h002;
   localparam logic [9:0] P_TIME    = 10'h008;
   localparam logic [9:0] P_RSV0    = 10'h00E;
   localparam logic [9:0] P_NMEA    = 10'h012;
   localparam logic [9:0] P_PAD     = 10'h066;
   localparam logic [9:0] P_STATUS  = 10'h1FA;
   localparam logic [9:0] P_PPS     = 10'h1FB;
   localparam logic [6:0] NMEA_LEN  = 7'h54;
   localparam logic [7:0] MARK_HI   = 8'hFF;
   localparam logic [7:0] MARK_LO   = 8'hEE;
   localparam logic [7:0] PAD_BYTE  = 8'hDF;
   // NMEA characters.
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_COMMA  = 8'h2C;
   localparam logic [7:0] CH_STAR   = 8'h2A;
   localparam logic [23:0] TYPE_RMC = 24'h524D43;
   localparam logic [23:0] TYPE_GGA = 24'h474741;
   localparam logic [3:0] F_TIME    = 4'h1;
   localparam logic [3:0] F_RMC_ST  = 4'h2;
   localparam logic [3:0] F_GGA_ST  = 4'h6;
   localparam logic [3:0] F_DATE    = 4'h9;
   // Timing: clock period, one microsecond, second and lock timeouts.
   localparam int CLK_NS       = 50;
   localparam int US_NS        = 1000;
   localparam int US_CYC       = (US_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEC_MS       = 1000;
   localparam int NMEA_TMO_MS  = 2000;
   localparam int CYC_PER_MS   = 1000000 / CLK_NS;
   localparam int SEC_CYC      = SEC_MS * CYC_PER_MS;
   localparam int NMEA_TMO_CYC = NMEA_TMO_MS * CYC_PER_MS;
   // Packet byte stream beat.
   typedef struct packed {
      logic       sop;
      logic       eop;
      logic [7:0] data;
   } tx_beat_t;
   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } tx_state_t;
endpackage

// ---- verilog/gps_time_packet_framer.sv ----
/*
 * GPS time packet framer: parses NMEA sentences, keeps the microsecond
 * timer and emits the once-per-second broadcast UDP time packet.
 * Assumes synchronous inputs, a byte sink with ready back-pressure and
 * a register master that never issues read and write together.
 */
// Implementation choices: the register offsets and the plain strobed port.
// What this block does
// - With GPS source, send one packet per second.
// - With PTP source, send no packets.
// - Numeric payload fields sent low byte first.
// - Source IP defaults to 192.168.1.201.
// - Destination IP is 255.255.255.255.
// - Broadcast destination MAC, then own MAC.
// - Frame type bytes 0x08 then 0x00.
// - UDP source port is 0x2710.
// - UDP destination port is 0x277E.
// - UDP length field holds 0x208.
// - Marker 0xFFEE, then date digits low first.
// - Time digits low first, then four reserved.
// - 84 NMEA bytes, then 404 bytes 0xDF.
// - RMC status: A, V, or zero unlocked.
// - GGA status: fix-quality digit passed through.
// - PPS lock byte, then four reserved bytes.
// - Microsecond counter clears on PPS rise.
// - NMEA unlocked after two silent seconds.
`timescale 1ns/100ps
module gps_time_packet_framer #(
   parameter int SEC_CYCLES  = gps_framer_pkg::SEC_CYC,
   parameter int NMEA_CYCLES = gps_framer_pkg::NMEA_TMO_CYC
) (
   // Clock and reset.
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_n_i,
   // Register port.
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [31:0]              reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output logic      [31:0]              reg_rdata_o,
   // GPS receiver side.
   input  wire logic                     nmea_valid_i,
   input  wire logic [7:0]               nmea_byte_i,
   input  wire logic                     pps_i,
   // Packet byte stream to the Ethernet transmit path.
   output gps_framer_pkg::tx_beat_t      tx_beat_o,
   output logic                          tx_valid_o,
   input  wire logic                     tx_ready_i
);
   // Registers written by software, and the packet counter.
   logic                 src_ptp;
   logic                 sel_gga;
   logic [31:0]          src_ip;
   logic [47:0]          src_mac;
   logic [31:0]          pkt_count;
   // Timing state.
   logic                 pps_d;
   logic [4:0]           us_div;
   logic [31:0]          us_time;
   logic [31:0]          sec_cnt;
   logic [31:0]          nmea_age;
   logic                 pps_lock;
   logic                 nmea_lock;
   // Parser state.
   logic                 in_sent;
   logic                 star_seen;
   logic [1:0]           tail;
   logic [6:0]           wr_ptr;
   logic [3:0]           field;
   logic [2:0]           fpos;
   logic [7:0]           tm_w [0:5];
   logic [7:0]           dt_w [0:5];
   logic [7:0]           st_w;
   logic [7:0]           tm_c [0:5];
   logic [7:0]           dt_c [0:5];
   logic [7:0]           st_c;
   logic [6:0]           len_w;
   logic [6:0]           len_c;
   logic                 rd_bank;
   logic                 pending;
   logic [7:0]           sent_mem [0:167];
   // Transmit state.
   gps_framer_pkg::tx_state_t state;
   logic [9:0]           idx;

   // Byte decode, tick and trigger terms.
   wire        pps_rise  = pps_i & ~pps_d;
   wire        us_tick   = (us_div == 5'(gps_framer_pkg::US_CYC - 1));
   wire        sec_wrap  = (sec_cnt == 32'(SEC_CYCLES - 1));
   wire        sec_tick  = pps_rise | sec_wrap;
   wire        trig      = sec_tick & ~src_ptp;
   wire        sending   = (state == gps_framer_pkg::TX_SEND);
   wire        is_dollar = nmea_valid_i &
                           (nmea_byte_i == gps_framer_pkg::CH_DOLLAR);
   wire        is_comma  = (nmea_byte_i == gps_framer_pkg::CH_COMMA);
   wire        is_star   = (nmea_byte_i == gps_framer_pkg::CH_STAR);
   wire [23:0] want_type = sel_gga ? gps_framer_pkg::TYPE_GGA
                                   : gps_framer_pkg::TYPE_RMC;
   wire [1:0]  type_pos  = 2'(wr_ptr - 7'h03);
   wire [7:0]  want_ch   = want_type[8*(2-type_pos)+:8];
   wire        type_bad  = (wr_ptr >= 7'h03) & (wr_ptr <= 7'h05) &
                           (nmea_byte_i != want_ch);
   wire        step      = nmea_valid_i & in_sent & ~is_dollar;
   wire        done      = step & star_seen & (tail == 2'h1);
   wire        commit    = (done | pending) & ~sending;
   wire        load      = ~tx_valid_o | tx_ready_i;
   wire [3:0]  st_field  = sel_gga ? gps_framer_pkg::F_GGA_ST
                                   : gps_framer_pkg::F_RMC_ST;
   wire        mem_we    = nmea_valid_i & (is_dollar | in_sent) &
                           (is_dollar | (wr_ptr < gps_framer_pkg::NMEA_LEN));
   wire [6:0]  mem_wa    = is_dollar ? 7'h00 : wr_ptr;
   wire [7:0]  mem_wi    = ~rd_bank ? (8'h54 + 8'(mem_wa)) : 8'(mem_wa);

   // Header checksum over the fixed IP words and the source address.
   function automatic logic [15:0] ip_csum(input logic [31:0] sip);
      logic [31:0] s;
      s = 32'(gps_framer_pkg::IP_VER_TOS) + 32'(gps_framer_pkg::IP_TOTLEN) +
          32'(gps_framer_pkg::IP_ID) + 32'(gps_framer_pkg::IP_FRAG) +
          32'(gps_framer_pkg::IP_TTL_PRO) + 32'(sip[31:16]) +
          32'(sip[15:0]) + 32'h0001FFFE;
      s = 32'(s[15:0]) + 32'(s[31:16]);
      s = 32'(s[15:0]) + 32'(s[31:16]);
      return ~s[15:0];
   endfunction

   // The 42 header bytes, first byte in the top lane.
   wire [335:0] hdr = {gps_framer_pkg::MAC_BCAST, src_mac,
                       gps_framer_pkg::ETH_TYPE,
                       gps_framer_pkg::IP_VER_TOS,
                       gps_framer_pkg::IP_TOTLEN,
                       gps_framer_pkg::IP_ID, gps_framer_pkg::IP_FRAG,
                       gps_framer_pkg::IP_TTL_PRO, ip_csum(src_ip),
                       src_ip, gps_framer_pkg::IP_BCAST,
                       gps_framer_pkg::UDP_SPORT,
                       gps_framer_pkg::UDP_DPORT,
                       gps_framer_pkg::UDP_LEN,
                       gps_framer_pkg::UDP_CSUM};

   // Payload byte selection; digits go out units first.
   wire [9:0] p       = idx - gps_framer_pkg::HDR_LEN;
   wire [9:0] pd      = p - gps_framer_pkg::P_DATE;
   wire [9:0] pt      = p - gps_framer_pkg::P_TIME;
   wire [9:0] pn      = p - gps_framer_pkg::P_NMEA;
   wire [2:0] dsel    = 3'(3'h5 - 3'(pd));
   wire [2:0] tsel    = 3'(3'h5 - 3'(pt));
   wire [7:0] mem_ri  = rd_bank ? (8'h54 + 8'(pn)) : 8'(pn);
   wire [7:0] nmea_b  = (7'(pn) < len_c) ? sent_mem[mem_ri] : 8'h00;
   wire [7:0] stat_b  = (sel_gga | nmea_lock) ? st_c : 8'h00;
   logic [7:0] cur_byte;
   always_comb begin
      if (idx < gps_framer_pkg::HDR_LEN)
         cur_byte = hdr[8*(41-int'(idx))+:8];
      else if (p == 10'h000)
         cur_byte = gps_framer_pkg::MARK_HI;
      else if (p < gps_framer_pkg::P_DATE)
         cur_byte = gps_framer_pkg::MARK_LO;
      else if (p < gps_framer_pkg::P_TIME)
         cur_byte = dt_c[dsel];
      else if (p < gps_framer_pkg::P_RSV0)
         cur_byte = tm_c[tsel];
      else if (p < gps_framer_pkg::P_NMEA)
         cur_byte = 8'h00;
      else if (p < gps_framer_pkg::P_PAD)
         cur_byte = nmea_b;
      else if (p < gps_framer_pkg::P_STATUS)
         cur_byte = gps_framer_pkg::PAD_BYTE;
      else if (p == gps_framer_pkg::P_STATUS)
         cur_byte = stat_b;
      else if (p == gps_framer_pkg::P_PPS)
         cur_byte = {7'h00, pps_lock};
      else
         cur_byte = 8'h00;
   end

   // Register read multiplexer; unmapped offsets read zero.
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr_i)
         gps_framer_pkg::OFS_CTRL:   rd_mux = {30'h0, sel_gga, src_ptp};
         gps_framer_pkg::OFS_SRC_IP: rd_mux = src_ip;
         gps_framer_pkg::OFS_MAC_LO: rd_mux = src_mac[31:0];
         gps_framer_pkg::OFS_MAC_HI: rd_mux = {16'h0, src_mac[47:32]};
         gps_framer_pkg::OFS_STATUS: rd_mux = {29'h0, sending,
                                               pps_lock, nmea_lock};
         gps_framer_pkg::OFS_US:     rd_mux = us_time;
         gps_framer_pkg::OFS_PKTS:   rd_mux = pkt_count;
         default:                    rd_mux = 32'h0;
      endcase
   end

   // Register writes and the one-cycle read answer.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_ptp     <= 1'b0;
         sel_gga     <= 1'b0;
         src_ip      <= gps_framer_pkg::SRC_IP_RST;
         src_mac     <= gps_framer_pkg::MAC_RST;
         reg_rdata_o <= 32'h0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
         if (reg_wr_i && reg_addr_i == gps_framer_pkg::OFS_CTRL) begin
            src_ptp <= reg_wdata_i[gps_framer_pkg::CTRL_PTP_BIT];
            sel_gga <= reg_wdata_i[gps_framer_pkg::CTRL_GGA_BIT];
         end
         if (reg_wr_i && reg_addr_i == gps_framer_pkg::OFS_SRC_IP)
            src_ip <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == gps_framer_pkg::OFS_MAC_LO)
            src_mac[31:0] <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == gps_framer_pkg::OFS_MAC_HI)
            src_mac[47:32] <= reg_wdata_i[15:0];
      end
   end

   // Microsecond timer, second tick and PPS lock tracking.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pps_d    <= 1'b0;
         us_div   <= 5'h00;
         us_time  <= 32'h0;
         sec_cnt  <= 32'h0;
         pps_lock <= 1'b0;
      end else begin
         pps_d <= pps_i;
         if (pps_rise) begin
            us_div  <= 5'h00;
            us_time <= 32'h0;
         end else if (us_tick) begin
            us_div  <= 5'h00;
            us_time <= us_time + 32'h1;
         end else begin
            us_div  <= us_div + 5'h01;
         end
         sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
         if (pps_rise)
            pps_lock <= 1'b1;
         else if (sec_wrap)
            pps_lock <= 1'b0;
      end
   end

   // NMEA lock: set by a good sentence, dropped after two quiet seconds.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nmea_age  <= 32'h0;
         nmea_lock <= 1'b0;
      end else if (done) begin
         nmea_age  <= 32'h0;
         nmea_lock <= 1'b1;
      end else if (nmea_age >= 32'(NMEA_CYCLES - 1)) begin
         nmea_lock <= 1'b0;
      end else begin
         nmea_age  <= nmea_age + 32'h1;
      end
   end

   // Sentence store: two banks, the idle one takes the incoming text.
   always_ff @(posedge clk_sys_i) begin
      if (mem_we)
         sent_mem[mem_wi] <= nmea_byte_i;
   end

   // Sentence parser: type check, comma fields, end two chars past star.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_sent   <= 1'b0;
         star_seen <= 1'b0;
         tail      <= 2'h0;
         wr_ptr    <= 7'h00;
         field     <= 4'h0;
         fpos      <= 3'h0;
         st_w      <= 8'h00;
         len_w     <= 7'h00;
         for (int i = 0; i < 6; i++) begin
            tm_w[i] <= 8'h30;
            dt_w[i] <= 8'h30;
         end
      end else if (is_dollar) begin
         in_sent   <= 1'b1;
         star_seen <= 1'b0;
         tail      <= 2'h0;
         wr_ptr    <= 7'h01;
         field     <= 4'h0;
         fpos      <= 3'h0;
         st_w      <= 8'h00;
      end else if (step) begin
         if (wr_ptr < gps_framer_pkg::NMEA_LEN)
            wr_ptr <= wr_ptr + 7'h01;
         if (type_bad) begin
            in_sent <= 1'b0;
         end else if (star_seen) begin
            tail <= tail + 2'h1;
            if (tail == 2'h1) begin
               in_sent <= 1'b0;
               len_w   <= (wr_ptr < gps_framer_pkg::NMEA_LEN) ?
                          wr_ptr + 7'h01 : wr_ptr;
            end
         end else if (is_star) begin
            star_seen <= 1'b1;
         end else if (is_comma) begin
            field <= field + 4'h1;
            fpos  <= 3'h0;
         end else begin
            if (fpos != 3'h7)
               fpos <= fpos + 3'h1;
            if (field == gps_framer_pkg::F_TIME && fpos < 3'h6)
               tm_w[fpos] <= nmea_byte_i;
            if (!sel_gga && field == gps_framer_pkg::F_DATE &&
                fpos < 3'h6)
               dt_w[fpos] <= nmea_byte_i;
            if (field == st_field && fpos == 3'h0)
               st_w <= nmea_byte_i;
         end
      end
   end

   // Commit a finished sentence, waiting while a packet is on the wire.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_bank <= 1'b0;
         pending <= 1'b0;
         st_c    <= 8'h00;
         len_c   <= 7'h00;
         for (int i = 0; i < 6; i++) begin
            tm_c[i] <= 8'h30;
            dt_c[i] <= 8'h30;
         end
      end else if (commit) begin
         pending <= 1'b0;
         rd_bank <= ~rd_bank;
         st_c    <= st_w;
         len_c   <= done ? ((wr_ptr < gps_framer_pkg::NMEA_LEN) ?
                    wr_ptr + 7'h01 : wr_ptr) : len_w;
         tm_c    <= tm_w;
         dt_c    <= dt_w;
      end else if (done) begin
         pending <= 1'b1;
      end
   end

   // Transmit sequencer: one byte per accepted beat, held under stall.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state      <= gps_framer_pkg::TX_IDLE;
         idx        <= 10'h000;
         tx_valid_o <= 1'b0;
         tx_beat_o  <= '0;
         pkt_count  <= 32'h0;
      end else begin
         case (state)
            gps_framer_pkg::TX_IDLE: begin
               if (load)
                  tx_valid_o <= 1'b0;
               if (trig) begin
                  state <= gps_framer_pkg::TX_SEND;
                  idx   <= 10'h000;
               end
            end
            gps_framer_pkg::TX_SEND: begin
               if (load) begin
                  tx_valid_o     <= 1'b1;
                  tx_beat_o.data <= cur_byte;
                  tx_beat_o.sop  <= (idx == 10'h000);
                  tx_beat_o.eop  <= (idx == gps_framer_pkg::PKT_LAST);
                  idx            <= idx + 10'h001;
                  if (idx == gps_framer_pkg::PKT_LAST) begin
                     state     <= gps_framer_pkg::TX_IDLE;
                     pkt_count <= pkt_count + 32'h1;
                  end
               end
            end
            default: state <= gps_framer_pkg::TX_IDLE;
         endcase
      end
   end
endmodule

// ---- testbench/gps_framer_props.sv ----
/* Port checker for the GPS time packet framer.
   Assumes it is bound to the framer top module with one clock. */
`timescale 1ns/100ps
module gps_framer_props (
   // Clock, reset and register port.
   input wire logic                     clk_sys_i,
   input wire logic                     rst_n_i,
   input wire logic [7:0]               reg_addr_i,
   input wire logic [31:0]              reg_wdata_i,
   input wire logic                     reg_wr_i,
   input wire logic                     reg_rd_i,
   input wire logic [31:0]              reg_rdata_o,
   // Receiver and stream side.
   input wire logic                     pps_i,
   input wire gps_framer_pkg::tx_beat_t tx_beat_o,
   input wire logic                     tx_valid_o,
   input wire logic                     tx_ready_i
);
   logic [9:0] idx;
   logic       ptp;
   wire        take = tx_valid_o && tx_ready_i;
   wire        ctl  = reg_wr_i && reg_addr_i == gps_framer_pkg::OFS_CTRL;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // Tracks the byte index on offer and a copy of the PTP select bit.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx <= 10'h000;
         ptp <= 1'b0;
      end else begin
         if (take) idx <= tx_beat_o.eop ? 10'h000 : idx + 10'h001;
         if (ctl) ptp <= reg_wdata_i[0];
      end
   end
   a_rdata_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 0)
      else $error("read data not zero outside read cycle");
   a_beat_hold: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_beat_o)) else $error("stalled beat moved");
   a_sop_first: assert property (tx_valid_o && tx_beat_o.sop |->
      idx == 0 && tx_beat_o.data == 8'hFF) else $error("bad first beat");
   a_eop_last: assert property (tx_valid_o && tx_beat_o.eop |-> idx == 553)
      else $error("packet length wrong");
   a_eth_type: assert property (tx_valid_o && idx == 12 |->
      tx_beat_o.data == 8'h08) else $error("frame type wrong");
   a_dest_ip: assert property (tx_valid_o && idx inside {[30:33]} |->
      tx_beat_o.data == 8'hFF) else $error("destination wrong");
   a_udp_sport: assert property (tx_valid_o && idx == 34 |->
      tx_beat_o.data == 8'h27) else $error("source port wrong");
   a_udp_csum: assert property (tx_valid_o && idx inside {[40:41]} |->
      tx_beat_o.data == 8'h00) else $error("checksum not zero");
   a_pad_fill: assert property (tx_valid_o && idx inside {[144:547]} |->
      tx_beat_o.data == 8'hDF) else $error("padding wrong");
   a_ptp_quiet: assert property (ptp && !tx_valid_o |=> !tx_valid_o)
      else $error("packet under PTP source");
   a_pps_start: assert property ($rose(pps_i) && !ptp && !tx_valid_o |->
      ##2 tx_valid_o && tx_beat_o.sop) else $error("no packet on PPS");
   c_eop: cover property (take && tx_beat_o.eop);
   c_stall: cover property (tx_valid_o && !tx_ready_i);
   c_pps_ptp: cover property ($rose(pps_i) && ptp);
endmodule

// ---- testbench/gps_partner.sv ----
/* GPS receiver and broadcast host model for the framer.
   Assumes a byte per clock on the NMEA side and a stalling host. */
`timescale 1ns/100ps
module gps_partner (
   // Clock and reset.
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_n_i,
   // Receiver outputs.
   output logic                          nmea_valid_o,
   output logic [7:0]                    nmea_byte_o,
   output logic                          pps_o,
   // Host side of the stream.
   input  wire gps_framer_pkg::tx_beat_t tx_beat_i,
   input  wire logic                     tx_valid_i,
   output logic                          tx_ready_o
);
   logic [7:0] cap [0:553];
   int         cnt  = 0;
   int         pkts = 0;
   logic [1:0] cyc  = 2'h0;
   initial begin
      nmea_valid_o = 1'b0;
      nmea_byte_o  = 8'h55;
      pps_o        = 1'b0;
   end
   // The host stalls one cycle in four.
   assign tx_ready_o = cyc != 2'h3;
   // Stores the bytes of the latest packet and counts whole packets.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 2'h1;
      if (tx_valid_i && tx_ready_o) begin
         cap[tx_beat_i.sop ? 0 : cnt] <= tx_beat_i.data;
         cnt <= tx_beat_i.sop ? 1 : cnt + 1;
         if (tx_beat_i.eop) pkts <= pkts + 1;
      end
   end
   // Sends a sentence; time and date sit in the fields the framer expects.
   task automatic send_line(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk_sys_i);
         nmea_valid_o <= 1'b1;
         nmea_byte_o  <= s[i];
      end
      @(posedge clk_sys_i);
      nmea_valid_o <= 1'b0;
      nmea_byte_o  <= ~s[s.len()-1];
   endtask
   // Raises the pulse for five cycles.
   task automatic pulse_pps();
      @(posedge clk_sys_i);
      pps_o <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      pps_o <= 1'b0;
   endtask
endmodule

// ---- testbench/testbench.sv ----
/* Self-checking bench for the GPS time packet framer.
   Assumes shortened second and lock counts and the partner model. */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module testbench;
   logic                     clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i;
   logic [7:0]               reg_addr_i, nmea_byte;
   logic [31:0]              reg_wdata_i, reg_rdata_o;
   logic                     nmea_valid, pps, tx_valid, tx_ready;
   gps_framer_pkg::tx_beat_t tx_beat;
   int                       err_count = 0;
   int                       tests_run = 0;
   string RMC = "$GPRMC,072242,A,3027.3680,N,11423.6975,E,000.0,316.7,160617,004.1,W*67";
   string GGA = "$GPGGA,123519,4807.038,N,01131.000,E,1,08,0.9,545.4,M,46.9,M,,*47";
   gps_time_packet_framer #(.SEC_CYCLES(2000), .NMEA_CYCLES(4000)) DUT (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .nmea_valid_i(nmea_valid),
      .nmea_byte_i(nmea_byte), .pps_i(pps), .tx_beat_o(tx_beat),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready));
   gps_partner u_host (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .nmea_valid_o(nmea_valid),
      .nmea_byte_o(nmea_byte), .pps_o(pps), .tx_beat_i(tx_beat),
      .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Register port cycles: one strobe cycle each.
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   // Waits a bounded time for one more whole packet.
   task automatic wait_pkt();
      int n = u_host.pkts;
      for (int i = 0; i < 3000 && u_host.pkts == n; i++) @(posedge clk_sys_i);
      `CHK(u_host.pkts != n, 1'b1)
      repeat (2) @(posedge clk_sys_i);
   endtask
   // Compares a captured packet with the layout.
   task automatic check_pkt(input string d, input string t, input string s,
                            input logic [7:0] st);
      logic [0:41][7:0] hdr = {48'hFFFFFFFFFFFF, 48'h020000000001, 16'h0800,
         80'h4500021C000040004011, 16'h0, 64'hC0A801C9FFFFFFFF,
         64'h2710277E02080000};
      for (int i = 0; i < 42; i++) begin
         if (i != 24 && i != 25) `CHK(u_host.cap[i], hdr[i])
      end
      `CHK({u_host.cap[42], u_host.cap[43]}, 16'hFFEE)
      for (int i = 0; i < 6; i++) begin
         `CHK(u_host.cap[44+i], d[i])
         `CHK(u_host.cap[50+i], t[i])
      end
      for (int i = 0; i < 84; i++) begin
         `CHK(u_host.cap[60+i], i < s.len() ? s[i] : 8'h00)
      end
      for (int i = 0; i < 4; i++) begin
         `CHK(u_host.cap[56+i], 8'h00)
         `CHK(u_host.cap[550+i], 8'h00)
      end
      `CHK(u_host.cap[548], st)
      `CHK(u_host.cap[549], 8'h01)
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #1000000;
      err_count++;
      give_verdict();
   end
   // Main sequence: RMC, GGA, PTP silence, lock loss.
   initial begin
      logic [31:0] v;
      int          n;
      rst_n_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      reg_read(gps_framer_pkg::OFS_SRC_IP, v);
      `CHK(v, 32'hC0A801C9)
      reg_read(8'h40, v);
      `CHK(v, 32'h0)
      u_host.send_line(RMC);
      u_host.pulse_pps();
      wait_pkt();
      check_pkt("716061", "242270", RMC, 8'h41);
      reg_read(gps_framer_pkg::OFS_STATUS, v);
      `CHK(v[1:0], 2'h3)
      reg_write(gps_framer_pkg::OFS_CTRL, 32'h2);
      u_host.send_line(GGA);
      u_host.pulse_pps();
      wait_pkt();
      check_pkt("716061", "915321", GGA, 8'h31);
      reg_write(gps_framer_pkg::OFS_CTRL, 32'h3);
      n = u_host.pkts;
      u_host.pulse_pps();
      reg_read(gps_framer_pkg::OFS_US, v);
      `CHK(v, 32'h0)
      repeat (398) @(posedge clk_sys_i);
      reg_read(gps_framer_pkg::OFS_US, v);
      `CHK(v, 32'h14)
      repeat (4100) @(posedge clk_sys_i);
      `CHK(u_host.pkts, n)
      reg_read(gps_framer_pkg::OFS_STATUS, v);
      `CHK(v, 32'h0)
      reg_write(gps_framer_pkg::OFS_CTRL, 32'h0);
      reg_write(gps_framer_pkg::OFS_MAC_LO, 32'h000000A5);
      wait_pkt();
      `CHK(u_host.cap[11], 8'hA5)
      `CHK(u_host.cap[548], 8'h00)
      `CHK(u_host.cap[549], 8'h00)
      reg_read(gps_framer_pkg::OFS_PKTS, v);
      `CHK(v, 32'h3)
      give_verdict();
   end
endmodule
bind gps_time_packet_framer gps_framer_props u_props (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .pps_i(pps_i), .tx_beat_o(tx_beat_o),
   .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
